// file: epi_ctrl.sv
// External pin interrupt detection, flags, masks and sleep wake-up.
// Assumes pins are asynchronous, core signals share REF_CLK_IN.
`default_nettype none

// Overview of operation
// - Pin input sensed even when driven locally
// - Level mode requests while pin stays low
// - Upper edge detection needs running I/O clock
// - Deep sleep: only clock-free detections wake
// - Level wake: two watchdog samples, startup gate
// - Lower codes: low, reserved, fall, rise
// - Upper codes: low, any change, fall, rise
// - Upper pins sampled before edge compare
// - Request needs global enable and mask
// - Two sense registers, two bits per pin
// - Mask bits enable, reset zero, read/write
// - Edge or change sets pin flag
// - Flag clears on vector entry or one
// - Level-mode pin flags always read zero
// - Sleep disables masked lower input buffers
// - Legacy mode hides lower sense register
module epi_ctrl #(
    parameter int STARTUP_CYCLES = epi_pkg::STARTUP_CYC
) (
    input  wire logic                          REF_CLK_IN,
    input  wire logic                          ARST_N_IN,
    input  wire logic [epi_pkg::NPINS-1:0]     EXT_IRQ_PINS_IN,
    input  wire logic                          GLOBAL_IE_IN,
    input  wire logic [epi_pkg::NPINS-1:0]     VEC_ENTRY_IN,
    input  wire logic                          SLEEP_IN,
    input  wire logic                          DEEP_SLEEP_IN,
    input  wire logic                          WDT_TICK_IN,
    input  wire logic                          LEGACY_COMPAT_IN,
    input  wire logic [epi_pkg::AXI_ADDR_W-1:0] AXI_AWADDR_IN,
    input  wire logic                          AXI_AWVALID_IN,
    output logic                               AXI_AWREADY_OUT,
    input  wire logic [epi_pkg::AXI_DATA_W-1:0] AXI_WDATA_IN,
    input  wire logic [3:0]                    AXI_WSTRB_IN,
    input  wire logic                          AXI_WVALID_IN,
    output logic                               AXI_WREADY_OUT,
    output logic [1:0]                         AXI_BRESP_OUT,
    output logic                               AXI_BVALID_OUT,
    input  wire logic                          AXI_BREADY_IN,
    input  wire logic [epi_pkg::AXI_ADDR_W-1:0] AXI_ARADDR_IN,
    input  wire logic                          AXI_ARVALID_IN,
    output logic                               AXI_ARREADY_OUT,
    output logic [epi_pkg::AXI_DATA_W-1:0]     AXI_RDATA_OUT,
    output logic [1:0]                         AXI_RRESP_OUT,
    output logic                               AXI_RVALID_OUT,
    input  wire logic                          AXI_RREADY_IN,
    output logic [epi_pkg::NPINS-1:0]          CORE_IRQ_OUT,
    output logic                               IRQ_OUT,
    output logic                               WAKE_OUT
);
    localparam int N = epi_pkg::NPINS;

    logic [7:0]                      low_pins_sense_control;
    logic [7:0]                      high_pins_sense_control;
    logic [N-1:0]                    pin_interrupt_mask;
    logic [N-1:0]                    pin_irq_flag;
    logic [N-1:0]                    pin_meta;
    logic [N-1:0]                    pin_sync;
    logic [N-1:0]                    pin_prev;
    logic [N-1:0]                    pin_eff;
    logic [N-1:0]                    evt_set;
    logic [N-1:0]                    evt_clr;
    logic [N-1:0]                    lvl_mode;
    logic [N-1:0]                    pend;
    logic [2*N-1:0]                  sense_all;
    logic [epi_pkg::AXI_ADDR_W-1:0]  aw_addr;
    logic [epi_pkg::AXI_DATA_W-1:0]  w_data;
    logic [3:0]                      w_strb;
    logic                            aw_full;
    logic                            w_full;
    logic                            wr_go;
    logic                            wr_byte0;
    logic                            startup_hold;
    logic                            lvl_wake;
    logic [31:0]                     start_cnt;
    epi_pkg::epi_wake_e              wake_st;

    // Pins pass two flops before any logic sees them
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            // Idle pull-up level, so release gives no false fall or level
            pin_meta <= '1;
            pin_sync <= '1;
            pin_prev <= '1;
        end else begin
            pin_meta <= EXT_IRQ_PINS_IN;
            pin_sync <= pin_meta;
            pin_prev <= pin_eff;
        end
    end

    // Pin level is sensed regardless of direction, so self-driven pins fire
    // Masked lower pins lose their input buffer in sleep, reading low
    always_comb begin
        pin_eff = pin_sync;
        for (int k = 0; k < epi_pkg::NLOW; k++) begin
            if (SLEEP_IN && !pin_interrupt_mask[k]) begin
                pin_eff[k] = 1'b0;
            end
        end
    end

    assign sense_all = {high_pins_sense_control, low_pins_sense_control};
    assign wr_go     = aw_full && w_full && !AXI_BVALID_OUT;
    assign wr_byte0  = wr_go && w_strb[0];

    // Flag clear by one via flags or clear alias, or by vector entry
    always_comb begin
        evt_clr = VEC_ENTRY_IN;
        if (wr_byte0 && (aw_addr == epi_pkg::OFS_FLAGS || aw_addr == epi_pkg::OFS_FCLR)) begin
            evt_clr = evt_clr | w_data[N-1:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            epi_pkg::epi_sense_s sns;
            logic                fall;
            logic                rise;
            assign sns  = epi_pkg::epi_sense_s'(sense_all[2*g +: 2]);
            assign fall = pin_prev[g] && !pin_eff[g];
            assign rise = !pin_prev[g] && pin_eff[g];
            assign lvl_mode[g] = ({sns.sense_sel_hi, sns.sense_sel_lo} == epi_pkg::SNS_LEVEL);
            if (g < epi_pkg::NLOW) begin : g_low
                // Reserved code detects nothing
                always_comb begin
                    case ({sns.sense_sel_hi, sns.sense_sel_lo})
                        epi_pkg::SNS_FALL: evt_set[g] = fall;
                        epi_pkg::SNS_RISE: evt_set[g] = rise;
                        default:           evt_set[g] = 1'b0;
                    endcase
                end
            end else begin : g_high
                // Edges on sampled values; halted I/O clock in deep sleep
                always_comb begin
                    case ({sns.sense_sel_hi, sns.sense_sel_lo})
                        epi_pkg::SNS_ANY:  evt_set[g] = (fall || rise) && !DEEP_SLEEP_IN;
                        epi_pkg::SNS_FALL: evt_set[g] = fall && !DEEP_SLEEP_IN;
                        epi_pkg::SNS_RISE: evt_set[g] = rise && !DEEP_SLEEP_IN;
                        default:           evt_set[g] = 1'b0;
                    endcase
                end
            end
            // Level mode forces flag low; otherwise set beats clear
            always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    pin_irq_flag[g] <= 1'b0;
                end else if (lvl_mode[g]) begin
                    pin_irq_flag[g] <= 1'b0;
                end else if (evt_set[g]) begin
                    pin_irq_flag[g] <= 1'b1;
                end else if (evt_clr[g]) begin
                    pin_irq_flag[g] <= 1'b0;
                end
            end
            // Level request persists while low
            assign pend[g] = lvl_mode[g] ? !pin_eff[g] : pin_irq_flag[g];
        end
    endgenerate

    // Requests need global enable and mask; held off during start-up
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            CORE_IRQ_OUT <= '0;
            IRQ_OUT      <= 1'b0;
        end else begin
            CORE_IRQ_OUT <= pend & pin_interrupt_mask & {N{GLOBAL_IE_IN && !startup_hold}};
            IRQ_OUT      <= |(pend & pin_interrupt_mask) && GLOBAL_IE_IN && !startup_hold;
        end
    end

    assign startup_hold = (wake_st == epi_pkg::WK_START);
    assign lvl_wake     = |(lvl_mode & ~pin_eff & pin_interrupt_mask);

    // Level wake needs two watchdog samples; edges wake at once from WK_SLEEP, not from WK_SEEN
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            wake_st   <= epi_pkg::WK_RUN;
            start_cnt <= '0;
            WAKE_OUT  <= 1'b0;
        end else begin
            WAKE_OUT <= 1'b0;
            case (wake_st)
                epi_pkg::WK_RUN: begin
                    if (SLEEP_IN) begin
                        wake_st <= epi_pkg::WK_SLEEP;
                    end
                end
                epi_pkg::WK_SLEEP: begin
                    if (!SLEEP_IN) begin
                        wake_st <= epi_pkg::WK_RUN;
                    end else if (|(evt_set & pin_interrupt_mask)) begin
                        wake_st   <= epi_pkg::WK_START;
                        start_cnt <= 32'(STARTUP_CYCLES);
                        WAKE_OUT  <= 1'b1;
                    end else if (WDT_TICK_IN && lvl_wake) begin
                        wake_st <= epi_pkg::WK_SEEN;
                    end
                end
                epi_pkg::WK_SEEN: begin
                    if (!SLEEP_IN) begin
                        wake_st <= epi_pkg::WK_RUN;
                    end else if (WDT_TICK_IN) begin
                        if (lvl_wake) begin
                            wake_st   <= epi_pkg::WK_START;
                            start_cnt <= 32'(STARTUP_CYCLES);
                            WAKE_OUT  <= 1'b1;
                        end else begin
                            wake_st <= epi_pkg::WK_SLEEP;
                        end
                    end
                end
                epi_pkg::WK_START: begin
                    // Core wakes anyway; a vanished level leaves no request
                    if (start_cnt <= 32'd1) begin
                        wake_st <= epi_pkg::WK_RUN;
                    end else begin
                        start_cnt <= start_cnt - 32'd1;
                    end
                end
                default: wake_st <= epi_pkg::WK_RUN;
            endcase
        end
    end

    // Write channel: address and data captured in either order
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            aw_full         <= 1'b0;
            w_full          <= 1'b0;
            aw_addr         <= '0;
            w_data          <= '0;
            w_strb          <= '0;
            AXI_AWREADY_OUT <= 1'b0;
            AXI_WREADY_OUT  <= 1'b0;
            AXI_BVALID_OUT  <= 1'b0;
            AXI_BRESP_OUT   <= epi_pkg::RESP_OKAY;
        end else begin
            AXI_AWREADY_OUT <= !aw_full && !(AXI_AWVALID_IN && AXI_AWREADY_OUT);
            AXI_WREADY_OUT  <= !w_full && !(AXI_WVALID_IN && AXI_WREADY_OUT);
            if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
                aw_full <= 1'b1;
                aw_addr <= AXI_AWADDR_IN;
            end
            if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
                w_full <= 1'b1;
                w_data <= AXI_WDATA_IN;
                w_strb <= AXI_WSTRB_IN;
            end
            if (wr_go) begin
                AXI_BVALID_OUT <= 1'b1;
                case (aw_addr)
                    epi_pkg::OFS_LSENSE: AXI_BRESP_OUT <= LEGACY_COMPAT_IN ?
                                                          epi_pkg::RESP_SLVERR : epi_pkg::RESP_OKAY;
                    epi_pkg::OFS_HSENSE, epi_pkg::OFS_MASK, epi_pkg::OFS_FLAGS,
                    epi_pkg::OFS_FCLR:   AXI_BRESP_OUT <= epi_pkg::RESP_OKAY;
                    default:             AXI_BRESP_OUT <= epi_pkg::RESP_SLVERR;
                endcase
            end
            if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
                AXI_BVALID_OUT  <= 1'b0;
                aw_full         <= 1'b0;
                w_full          <= 1'b0;
                AXI_AWREADY_OUT <= 1'b1;
                AXI_WREADY_OUT  <= 1'b1;
            end
        end
    end

    // Register storage; mask resets to zero
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            low_pins_sense_control  <= epi_pkg::RST_SENSE;
            high_pins_sense_control <= epi_pkg::RST_SENSE;
            pin_interrupt_mask      <= epi_pkg::RST_MASK;
        end else if (wr_byte0) begin
            case (aw_addr)
                // Unreachable in legacy mode; reset value means low level
                epi_pkg::OFS_LSENSE: begin
                    if (!LEGACY_COMPAT_IN) begin
                        low_pins_sense_control <= w_data[7:0];
                    end
                end
                epi_pkg::OFS_HSENSE: high_pins_sense_control <= w_data[7:0];
                epi_pkg::OFS_MASK:   pin_interrupt_mask      <= w_data[N-1:0];
                default: ;
            endcase
        end
    end

    // Read channel: one outstanding read, answer one cycle after address
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            AXI_ARREADY_OUT <= 1'b0;
            AXI_RVALID_OUT  <= 1'b0;
            AXI_RDATA_OUT   <= '0;
            AXI_RRESP_OUT   <= epi_pkg::RESP_OKAY;
        end else begin
            AXI_ARREADY_OUT <= !AXI_RVALID_OUT && !(AXI_ARVALID_IN && AXI_ARREADY_OUT);
            if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
                AXI_RVALID_OUT <= 1'b1;
                AXI_RRESP_OUT  <= epi_pkg::RESP_OKAY;
                AXI_RDATA_OUT  <= '0;
                case (AXI_ARADDR_IN)
                    epi_pkg::OFS_LSENSE: begin
                        if (LEGACY_COMPAT_IN) begin
                            AXI_RRESP_OUT <= epi_pkg::RESP_SLVERR;
                        end else begin
                            AXI_RDATA_OUT[7:0] <= low_pins_sense_control;
                        end
                    end
                    epi_pkg::OFS_HSENSE: AXI_RDATA_OUT[7:0]   <= high_pins_sense_control;
                    epi_pkg::OFS_MASK:   AXI_RDATA_OUT[N-1:0] <= pin_interrupt_mask;
                    epi_pkg::OFS_FLAGS:  AXI_RDATA_OUT[N-1:0] <= pin_irq_flag;
                    epi_pkg::OFS_FCLR:   AXI_RDATA_OUT        <= '0;
                    epi_pkg::OFS_PINLVL: AXI_RDATA_OUT[N-1:0] <= pin_eff;
                    default:             AXI_RRESP_OUT        <= epi_pkg::RESP_SLVERR;
                endcase
            end
            if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
                AXI_RVALID_OUT  <= 1'b0;
                AXI_ARREADY_OUT <= 1'b1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    property p_req_gated;
        (CORE_IRQ_OUT & ~$past(pin_interrupt_mask & {N{GLOBAL_IE_IN}})) == '0;
    endproperty
    a_req_gated: assert property (p_req_gated) else $error("request without enable");

    property p_level_req;
        logic [N-1:0] v;
        (|(lvl_mode & ~pin_eff & pin_interrupt_mask) && GLOBAL_IE_IN && !startup_hold,
         v = lvl_mode & ~pin_eff & pin_interrupt_mask) |=> ((CORE_IRQ_OUT & v) == v);
    endproperty
    a_level_req: assert property (p_level_req) else $error("level request missing");

    property p_level_flag_zero;
        (pin_irq_flag & $past(lvl_mode)) == '0;
    endproperty
    a_level_flag_zero: assert property (p_level_flag_zero) else $error("level flag set");

    property p_flag_set;
        logic [N-1:0] v;
        (|(evt_set & ~lvl_mode), v = evt_set & ~lvl_mode) |=> ((pin_irq_flag & v) == v);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_clr;
        logic [N-1:0] v;
        (|(evt_clr & ~evt_set), v = evt_clr & ~evt_set) |=> ((pin_irq_flag & v) == '0);
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

    property p_reserved;
        (low_pins_sense_control[1:0] == epi_pkg::SNS_ANY) |-> !evt_set[0];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code fired");

    property p_deep_upper;
        DEEP_SLEEP_IN |-> (evt_set[N-1:epi_pkg::NLOW] == '0);
    endproperty
    a_deep_upper: assert property (p_deep_upper) else $error("edge in deep sleep");

    property p_any_change;
        (high_pins_sense_control[1:0] == epi_pkg::SNS_ANY && !DEEP_SLEEP_IN
         && pin_prev[4] != pin_eff[4]) |=> pin_irq_flag[4];
    endproperty
    a_any_change: assert property (p_any_change) else $error("change missed");

    property p_legacy_lock;
        LEGACY_COMPAT_IN && $past(LEGACY_COMPAT_IN) |-> $stable(low_pins_sense_control);
    endproperty
    a_legacy_lock: assert property (p_legacy_lock) else $error("legacy write taken");

    property p_buf_off;
        (SLEEP_IN && !pin_interrupt_mask[0]) |-> !pin_eff[0];
    endproperty
    a_buf_off: assert property (p_buf_off) else $error("buffer not disabled");

    property p_wake_hold;
        WAKE_OUT |-> (wake_st == epi_pkg::WK_START) ##1 (CORE_IRQ_OUT == '0);
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("request in startup");

    property p_c_level_wake;
        (wake_st == epi_pkg::WK_SEEN) ##[1:1000] WAKE_OUT;
    endproperty
    c_level_wake: cover property (p_c_level_wake);
    c_edge_flag:  cover property (evt_set[0] ##1 pin_irq_flag[0]);
    c_set_clr:    cover property (|(evt_set & evt_clr));
    c_wr_resp:    cover property (wr_go ##[1:8] (AXI_BVALID_OUT && AXI_BREADY_IN));
endmodule // epi_ctrl

`default_nettype wire

// file: epi_pin_src.sv
// Behavioural source for the eight external interrupt pins.
// Assumes the bench commands pin levels synchronously to the core clock.
`default_nettype none

module epi_pin_src (
    input  wire logic       clk_in,
    input  wire logic [7:0] lvl_in,
    output logic [7:0]      pins_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle high as with pull-ups, so no level request before commands
    initial pins_out = 8'hff;
    // Each level is held until the next command, long enough to be seen
    always @(posedge clk_in) pins_out <= lvl_in;
endmodule // epi_pin_src

`default_nettype wire

// file: epi_pkg.sv
// Constants, codes and carrier types for the external pin interrupt block.
// Assumes a single 100 MHz core clock and an AXI4-Lite register bus.
`default_nettype none

package epi_pkg;
    localparam int          NPINS      = 8;
    localparam int          NLOW       = 4;
    localparam int          AXI_ADDR_W = 8;
    localparam int          AXI_DATA_W = 32;
    localparam int          REG_W      = 8;

    // Register byte addresses
    localparam logic [7:0]  OFS_LSENSE = 8'h00;
    localparam logic [7:0]  OFS_HSENSE = 8'h04;
    localparam logic [7:0]  OFS_MASK   = 8'h08;
    localparam logic [7:0]  OFS_FLAGS  = 8'h0c;
    localparam logic [7:0]  OFS_FCLR   = 8'h10;
    localparam logic [7:0]  OFS_PINLVL = 8'h14;

    localparam logic [7:0]  RST_SENSE  = 8'h00;
    localparam logic [7:0]  RST_MASK   = 8'h00;
    localparam logic [7:0]  RST_FLAGS  = 8'h00;

    localparam logic [1:0]  SNS_LEVEL  = 2'h0;
    localparam logic [1:0]  SNS_ANY    = 2'h1;
    localparam logic [1:0]  SNS_FALL   = 2'h2;
    localparam logic [1:0]  SNS_RISE   = 2'h3;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Wake start-up delay
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          STARTUP_NS    = 65000;
    localparam int          STARTUP_CYC   = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic sense_sel_hi;
        logic sense_sel_lo;
    } epi_sense_s;

    typedef enum logic [1:0] {
        WK_RUN,
        WK_SLEEP,
        WK_SEEN,
        WK_START
    } epi_wake_e;
endpackage : epi_pkg

`default_nettype wire

// file: external_pin_interrupts_tb_top.sv
// Self-checking bench for epi_ctrl: AXI4-Lite tasks and pin scenarios.
// Assumes epi_pkg and epi_ctrl are compiled first; start-up count is 8.
`default_nettype none

module external_pin_interrupts_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, ie = 0, slp = 0, dslp = 0, wdt = 0, leg = 0;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic        awr, wrdy, bv, arr, rv, irq, wake;
    logic [7:0]  awa = 8'h00, ara = 8'h00, vec = 8'h00, lvl = 8'hff, pins, cirq;
    logic [31:0] wd = 32'h0, rdat;
    logic [3:0]  ws = 4'hf;
    logic [1:0]  br, rr;
    int          err_total = 0, n_checks = 0, nwk = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (wake === 1'b1) nwk <= nwk + 1;

    epi_pin_src src (.clk_in(clk), .lvl_in(lvl), .pins_out(pins));
    epi_ctrl #(.STARTUP_CYCLES(8)) dut (.REF_CLK_IN(clk), .ARST_N_IN(rst_n),
        .EXT_IRQ_PINS_IN(pins), .GLOBAL_IE_IN(ie), .VEC_ENTRY_IN(vec), .SLEEP_IN(slp),
        .DEEP_SLEEP_IN(dslp), .WDT_TICK_IN(wdt), .LEGACY_COMPAT_IN(leg),
        .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
        .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrdy),
        .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bre),
        .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
        .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv),
        .AXI_RREADY_IN(rre), .CORE_IRQ_OUT(cirq), .IRQ_OUT(irq), .WAKE_OUT(wake));

    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta, tw;
        ta = 0;
        tw = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            ta = ta | awr;
            tw = tw | wrdy;
            awv <= !ta;
            wv <= !tw;
        end
        // Ready stays high: dropping and raising it in one step would race
        while (bv !== 1'b1) @(posedge clk);
        chk({30'h0, br}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        chk(rdat, e);
        chk({30'h0, rr}, {30'h0, er});
    endtask

    initial begin
        cyc(20000);
        err_total++;
        end_sim();
    end

    initial begin
        cyc(3);
        rst_n <= 1'b1;
        cyc(1);
        rd(epi_pkg::OFS_MASK, 32'h0, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_LSENSE, 32'h0, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_HSENSE, 32'h0, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_FLAGS, 32'h0, epi_pkg::RESP_OKAY);
        rd(8'h18, 32'h0, epi_pkg::RESP_SLVERR);
        wr(epi_pkg::OFS_MASK, 32'ha5, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_MASK, 32'ha5, epi_pkg::RESP_OKAY);
        wr(epi_pkg::OFS_MASK, 32'h0, epi_pkg::RESP_OKAY);
        // Pin0 fall, pin1 rise, pins 2-3 level; pin4/6 any, pin5 rise, pin7 fall
        wr(epi_pkg::OFS_LSENSE, 32'h0e, epi_pkg::RESP_OKAY);
        wr(epi_pkg::OFS_HSENSE, 32'h9d, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_HSENSE, 32'h9d, epi_pkg::RESP_OKAY);
        wr(epi_pkg::OFS_FLAGS, 32'hff, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_FLAGS, 32'h0, epi_pkg::RESP_OKAY);
        lvl <= 8'h4c;
        cyc(8);
        rd(epi_pkg::OFS_FLAGS, 32'h91, epi_pkg::RESP_OKAY);
        wr(epi_pkg::OFS_FLAGS, 32'hff, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_FLAGS, 32'h0, epi_pkg::RESP_OKAY);
        lvl <= 8'hff;
        cyc(8);
        rd(epi_pkg::OFS_FLAGS, 32'h32, epi_pkg::RESP_OKAY);
        vec <= 8'h02;
        cyc(1);
        vec <= 8'h00;
        rd(epi_pkg::OFS_FLAGS, 32'h30, epi_pkg::RESP_OKAY);
        wr(epi_pkg::OFS_FLAGS, 32'h0, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_FLAGS, 32'h30, epi_pkg::RESP_OKAY);
        ie <= 1'b1;
        wr(epi_pkg::OFS_MASK, 32'h10, epi_pkg::RESP_OKAY);
        cyc(4);
        chk({24'h0, cirq}, 32'h10);
        chk({31'h0, irq}, 32'h1);
        ie <= 1'b0;
        cyc(4);
        chk({31'h0, irq}, 32'h0);
        ie <= 1'b1;
        wr(epi_pkg::OFS_FLAGS, 32'h30, epi_pkg::RESP_OKAY);
        cyc(4);
        chk({31'h0, irq}, 32'h0);
        wr(epi_pkg::OFS_MASK, 32'h04, epi_pkg::RESP_OKAY);
        lvl <= 8'hfb;
        cyc(25);
        chk({24'h0, cirq}, 32'h04);
        rd(epi_pkg::OFS_FLAGS, 32'h0, epi_pkg::RESP_OKAY);
        lvl <= 8'hff;
        cyc(6);
        chk({31'h0, irq}, 32'h0);
        // Pin0 masked off, so sleep pulls its level low and its fall sets a flag
        slp <= 1'b1;
        cyc(6);
        rd(epi_pkg::OFS_FLAGS, 32'h01, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_PINLVL, 32'hf4, epi_pkg::RESP_OKAY);
        wr(epi_pkg::OFS_FCLR, 32'h01, epi_pkg::RESP_OKAY);
        rd(epi_pkg::OFS_FLAGS, 32'h0, epi_pkg::RESP_OKAY);
        dslp <= 1'b1;
        lvl <= 8'hfb;
        cyc(4);
        repeat (2) begin
            wdt <= 1'b1;
            cyc(1);
            wdt <= 1'b0;
            cyc(3);
        end
        cyc(2);
        chk(nwk, 32'h1);
        chk({31'h0, irq}, 32'h0);
        cyc(20);
        chk({31'h0, irq}, 32'h1);
        slp <= 1'b0;
        dslp <= 1'b0;
        lvl <= 8'hff;
        leg <= 1'b1;
        wr(epi_pkg::OFS_LSENSE, 32'h55, epi_pkg::RESP_SLVERR);
        rd(epi_pkg::OFS_LSENSE, 32'h0, epi_pkg::RESP_SLVERR);
        leg <= 1'b0;
        rd(epi_pkg::OFS_LSENSE, 32'h0e, epi_pkg::RESP_OKAY);
        end_sim();
    end
endmodule // external_pin_interrupts_tb_top

`default_nettype wire
